// *** tsacs_pkg.sv ***
// Purpose: constants, types and state layout for the touch converter config/status block
// Assumes: timebase tick of nominal 8 MHz from oscillator or divided master clock
// Notes:   delays are counted in timebase ticks, so they scale with the tick rate
package tsacs_pkg;

  // register offsets
  localparam logic [7:0] OFF_PANEL  = 8'h05;
  localparam logic [7:0] OFF_REF    = 8'h06;
  localparam logic [7:0] OFF_RSVA   = 8'h07;
  localparam logic [7:0] OFF_RSVB   = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h09;
  localparam logic [7:0] OFF_BUFFER = 8'h0d;

  // field positions
  localparam int PANEL_LSB   = 0;
  localparam int REF_SEL_BIT = 7;
  localparam int REF_LVL_BIT = 6;
  localparam int REF_PWR_BIT = 5;
  localparam int REF_STB_LSB = 2;
  localparam int REF_BAT_BIT = 0;
  localparam int ST_PEN_BIT  = 7;
  localparam int ST_IDLE_BIT = 6;
  localparam int ST_NEW_BIT  = 5;
  localparam int ST_RSV_BIT  = 4;
  localparam int BUF_EN_BIT  = 7;

  // values after reset
  localparam logic [7:0] RST_PANEL  = 8'h00;
  localparam logic [7:0] RST_REF    = 8'h20;
  localparam logic [7:0] RST_RSV    = 8'h00;
  localparam logic [7:0] RST_BUFFER = 8'h00;

  // settling times in ns, as nominal at an 8 MHz timebase
  localparam int TB_PERIOD_NS = 125;
  localparam int PANEL_NS [8] = '{250, 1000, 3000, 10000, 30000, 100000, 300000, 1000000};
  localparam int REF_NS   [4] = '{0, 100000, 500000, 1000000};

  // tick counts, least times rounded up
  localparam int CNT_W = 14;

  typedef enum logic [1:0] {
    TSACS_IDLE   = 2'b00,
    TSACS_PANEL  = 2'b01,
    TSACS_REFS   = 2'b10,
    TSACS_SAMPLE = 2'b11
  } tsacs_state_e;

  // conversion request carrier
  typedef struct packed {
    logic       touch;
    logic [1:0] chan;
  } tsacs_req_s;

  // whole state of the block
  typedef struct packed {
    tsacs_state_e     st;
    logic [CNT_W-1:0] cnt;
    logic             busy;
    logic             touch;
    logic [1:0]       chan;
    logic             sample;
    logic [7:0]       panel;
    logic [7:0]       refc;
    logic [7:0]       rsva;
    logic [7:0]       rsvb;
    logic             st_rsv;
    logic [7:0]       bufc;
    logic             ptr_clr;
    logic             pen;
    logic [3:0]       fresh;
    logic             ref_pwr;
    logic [7:0]       rdata;
  } tsacs_state_s;

endpackage : tsacs_pkg

// *** tsacs_top.sv ***
// Purpose: settling control, reference setup and new-data status for the touch converter
// Assumes: register port, ticks and conversion handshakes are synchronous to sys_clk_i
// Notes:   result readout logic pulses result_rd_i when a result has been read out
// Behaviour
// [RQ1] panel settle delay from 3-bit code
// [RQ2] delays count timebase ticks, scaling with source
// [RQ3] host writes zeros to unused panel bits
// [RQ4] reference select bit picks external or internal
// [RQ5] level bit picks 1.25 V or 2.5 V
// [RQ6] power bit gives continuous or automatic reference
// [RQ7] reference settle delay from 2-bit code
// [RQ8] battery bit selects auxiliary or battery measurement
// [RQ9] read-only pen touch flag
// [RQ10] idle flag low while converting, reset high
// [RQ11] summary flag clears when all results read
// [RQ12] per-coordinate flags clear on own read
// [RQ13] new-data flags meaningless in buffer mode
// [RQ14] host writes back reset contents to reserved
// [RQ15] buffer enable bit; clearing resets pointers
// [RQ16] settle delays precede sampling, idle low throughout
`timescale 1ns/1ps
module tsacs_top #(
  parameter int TB_NS = tsacs_pkg::TB_PERIOD_NS
) (
  // clock, reset, enable
  input  wire logic       sys_clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic       reg_wr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // timebase and conversion handshake
  input  wire logic       tick_i,
  input  wire logic       conv_req_i,
  input  wire logic       conv_touch_i,
  input  wire logic [1:0] conv_chan_i,
  input  wire logic       conv_done_i,
  output logic            sample_o,
  output logic            busy_o,
  // panel and result readout
  input  wire logic       pen_i,
  input  wire logic [3:0] result_rd_i,
  // analog controls
  output logic            ref_internal_o,
  output logic            ref_high_o,
  output logic            ref_power_o,
  output logic            battery_pin_mode_o,
  output logic      [2:0] panel_code_o,
  // buffer mode
  output logic            buffer_en_o,
  output logic            buffer_ptr_clear_o
);

  initial begin
    if (TB_NS <= 0) $error("timebase period must be positive");
  end

  // ticks for a least time, rounded up
  function automatic logic [tsacs_pkg::CNT_W-1:0] ns_to_ticks(input int ns);
    int t;
    t = (ns + TB_NS - 1) / TB_NS;
    return t[tsacs_pkg::CNT_W-1:0];
  endfunction : ns_to_ticks

  // panel settle count from code
  function automatic logic [tsacs_pkg::CNT_W-1:0] panel_ticks(input logic [2:0] code);
    return ns_to_ticks(tsacs_pkg::PANEL_NS[code]);
  endfunction : panel_ticks

  // reference settle count from code
  function automatic logic [tsacs_pkg::CNT_W-1:0] ref_ticks(input logic [1:0] code);
    return ns_to_ticks(tsacs_pkg::REF_NS[code]);
  endfunction : ref_ticks

  tsacs_pkg::tsacs_state_s s_q;
  tsacs_pkg::tsacs_state_s s_d;
  tsacs_pkg::tsacs_req_s   req;
  logic [3:0]              set_v;
  logic                    cnt_zero;
  logic [7:0]              status_v;

  assign req      = '{touch: conv_touch_i, chan: conv_chan_i};
  assign cnt_zero = (s_q.cnt == '0);

  // status byte assembly
  always_comb begin
    status_v = 8'h00;
    status_v[tsacs_pkg::ST_PEN_BIT]  = s_q.pen;                     // [RQ9]
    status_v[tsacs_pkg::ST_IDLE_BIT] = ~s_q.busy;                   // [RQ10]
    status_v[tsacs_pkg::ST_NEW_BIT]  = |s_q.fresh;                  // [RQ11]
    status_v[tsacs_pkg::ST_RSV_BIT]  = s_q.st_rsv;
    status_v[3]                      = s_q.fresh[0];                // [RQ12] horizontal
    status_v[2]                      = s_q.fresh[1];                // vertical
    status_v[1]                      = s_q.fresh[2];                // first pressure
    status_v[0]                      = s_q.fresh[3];                // second pressure
  end

  // next-state logic
  always_comb begin
    s_d         = s_q;
    s_d.sample  = 1'b0;
    s_d.ptr_clr = 1'b0;
    s_d.pen     = pen_i;
    set_v       = 4'h0;

    // settle and sample sequencing
    case (s_q.st)
      tsacs_pkg::TSACS_IDLE: begin
        if (conv_req_i) begin
          s_d.busy  = 1'b1;                                         // [RQ16]
          s_d.touch = req.touch;
          s_d.chan  = req.chan;
          if (req.touch) begin
            s_d.st  = tsacs_pkg::TSACS_PANEL;
            s_d.cnt = panel_ticks(s_q.panel[tsacs_pkg::PANEL_LSB +: 3]); // [RQ1]
          end else begin
            s_d.st  = tsacs_pkg::TSACS_REFS;
            s_d.cnt = ref_ticks(s_q.refc[tsacs_pkg::REF_STB_LSB +: 2]);  // [RQ7]
          end
        end
      end
      tsacs_pkg::TSACS_PANEL, tsacs_pkg::TSACS_REFS: begin
        if (cnt_zero) begin
          s_d.st     = tsacs_pkg::TSACS_SAMPLE;
          s_d.sample = 1'b1;                                        // [RQ16]
        end else if (tick_i) begin
          s_d.cnt = s_q.cnt - 1'b1;                                 // [RQ2]
        end
      end
      tsacs_pkg::TSACS_SAMPLE: begin
        if (conv_done_i) begin
          s_d.st   = tsacs_pkg::TSACS_IDLE;
          s_d.busy = 1'b0;                                          // [RQ10]
          if (s_q.touch && !s_q.bufc[tsacs_pkg::BUF_EN_BIT]) begin
            set_v[s_q.chan] = 1'b1;                                 // [RQ13]
          end
        end
      end
      default: begin
        s_d.st   = tsacs_pkg::TSACS_IDLE;
        s_d.busy = 1'b0;
      end
    endcase

    // fresh flags, a set beats a read in the same cycle
    s_d.fresh = (s_q.fresh & ~result_rd_i) | set_v;                 // [RQ12]

    // register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        tsacs_pkg::OFF_PANEL:  s_d.panel = reg_wdata_i;             // [RQ3]
        tsacs_pkg::OFF_REF:    s_d.refc  = reg_wdata_i;
        tsacs_pkg::OFF_RSVA:   s_d.rsva  = reg_wdata_i;             // [RQ14]
        tsacs_pkg::OFF_RSVB:   s_d.rsvb  = reg_wdata_i;
        tsacs_pkg::OFF_STATUS: s_d.st_rsv = reg_wdata_i[tsacs_pkg::ST_RSV_BIT];
        tsacs_pkg::OFF_BUFFER: begin
          s_d.bufc = reg_wdata_i;
          s_d.ptr_clr = ~reg_wdata_i[tsacs_pkg::BUF_EN_BIT];       // [RQ15]
        end
        default: ;
      endcase
    end

    // reference power gating, follows a mode write at once
    s_d.ref_pwr = ~s_d.refc[tsacs_pkg::REF_PWR_BIT] | s_d.busy;     // [RQ6]

    // register reads, unmapped reads as zero
    if (reg_rd_i) begin
      case (reg_addr_i)
        tsacs_pkg::OFF_PANEL:  s_d.rdata = s_q.panel;
        tsacs_pkg::OFF_REF:    s_d.rdata = s_q.refc;
        tsacs_pkg::OFF_RSVA:   s_d.rdata = s_q.rsva;
        tsacs_pkg::OFF_RSVB:   s_d.rdata = s_q.rsvb;
        tsacs_pkg::OFF_STATUS: s_d.rdata = status_v;
        tsacs_pkg::OFF_BUFFER: s_d.rdata = s_q.bufc;
        default:               s_d.rdata = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_q         <= '0;
      s_q.st      <= tsacs_pkg::TSACS_IDLE;
      s_q.panel   <= tsacs_pkg::RST_PANEL;
      s_q.refc    <= tsacs_pkg::RST_REF;
      s_q.rsva    <= tsacs_pkg::RST_RSV;
      s_q.rsvb    <= tsacs_pkg::RST_RSV;
      s_q.bufc    <= tsacs_pkg::RST_BUFFER;
      s_q.ref_pwr <= 1'b0;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  // outputs straight from state flops
  assign reg_rdata_o        = s_q.rdata;
  assign sample_o           = s_q.sample;
  assign busy_o             = s_q.busy;
  assign ref_internal_o     = s_q.refc[tsacs_pkg::REF_SEL_BIT];    // [RQ4]
  assign ref_high_o         = s_q.refc[tsacs_pkg::REF_LVL_BIT];    // [RQ5]
  assign ref_power_o        = s_q.ref_pwr;
  assign battery_pin_mode_o = s_q.refc[tsacs_pkg::REF_BAT_BIT];    // [RQ8]
  assign panel_code_o       = s_q.panel[tsacs_pkg::PANEL_LSB +: 3];
  assign buffer_en_o        = s_q.bufc[tsacs_pkg::BUF_EN_BIT];
  assign buffer_ptr_clear_o = s_q.ptr_clr;

endmodule : tsacs_top

// *** tsacs_chk_sva.sv ***
// Purpose: port-level assertions for the touch converter config/status block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound onto tsacs_top by the testbench
`timescale 1ns/1ps
module tsacs_chk (
  // clock, reset and requests
  input wire logic       sys_clk_i, rst_i, ce_i, conv_req_i, conv_done_i, reg_wr_i, conv_touch_i,
  // register write port
  input wire logic [7:0] reg_addr_i, reg_wdata_i,
  // watched outputs
  input wire logic       sample_o, busy_o, ref_internal_o, ref_high_o, ref_power_o,
  input wire logic       battery_pin_mode_o, buffer_en_o, buffer_ptr_clear_o,
  input wire logic [2:0] panel_code_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // accepted writes per register
  logic wr_ref, wr_pnl, wr_buf;
  assign wr_ref = ce_i && reg_wr_i && reg_addr_i == tsacs_pkg::OFF_REF;
  assign wr_pnl = ce_i && reg_wr_i && reg_addr_i == tsacs_pkg::OFF_PANEL;
  assign wr_buf = ce_i && reg_wr_i && reg_addr_i == tsacs_pkg::OFF_BUFFER;

  a_busy_start: assert property (!busy_o && conv_req_i && ce_i |=> busy_o)
    else $error("busy not raised after request");
  a_busy_end: assert property ($fell(busy_o) |-> $past(conv_done_i))
    else $error("busy dropped without done");
  a_settle_first: assert property (!busy_o && conv_req_i && conv_touch_i && ce_i |=> !sample_o ##1 !sample_o)
    else $error("sample before settling");
  a_sample_pulse: assert property (sample_o && ce_i |=> !sample_o)
    else $error("sample longer than one cycle");
  a_sample_busy: assert property (sample_o |-> busy_o)
    else $error("sample while idle");
  a_ref_power: assert property (busy_o |-> ref_power_o)
    else $error("reference off during conversion");
  a_ref_fields: assert property (wr_ref |=> {ref_internal_o, ref_high_o, battery_pin_mode_o} ==
    {$past(reg_wdata_i[7]), $past(reg_wdata_i[6]), $past(reg_wdata_i[0])}) else $error("reference fields wrong");
  a_panel_code: assert property (wr_pnl |=> panel_code_o == $past(reg_wdata_i[2:0]))
    else $error("panel code wrong");
  a_ptr_clear: assert property (wr_buf && !reg_wdata_i[7] |=> buffer_ptr_clear_o && !buffer_en_o)
    else $error("pointer clear missing");
endmodule : tsacs_chk

// *** tsacs_panel.sv ***
// Purpose: far-side model: panel contact, timebase ticks, result storage
// Assumes: sample strobe is a one-cycle pulse
// Notes:   slow_i stretches the time from sample to stored result
`timescale 1ns/1ps
module tsacs_panel (
  // clock and control
  input  wire logic clk_i, rst_i, sample_i, slow_i, touch_i,
  // toward the block
  output logic      tick_o, done_o, pen_o
);
  logic [3:0] wait_q;
  logic       arm_q;
  assign pen_o = touch_i;
  // ticks at half clock rate; done after a prompt or slow wait
  always_ff @(posedge clk_i) begin
    tick_o <= rst_i ? 1'b0 : ~tick_o;
    done_o <= !rst_i && arm_q && wait_q == 4'h0;
    if (rst_i || (arm_q && wait_q == 4'h0)) arm_q <= 1'b0;
    else if (sample_i) arm_q <= 1'b1;
    if (sample_i) wait_q <= slow_i ? 4'h6 : 4'h0;
    else if (wait_q != 4'h0) wait_q <= wait_q - 4'h1;
  end
endmodule : tsacs_panel

// *** test_touch_sar_adc_config_status.sv ***
// Purpose: self-checking bench for the touch converter config/status block
// Assumes: inputs driven at the falling edge, ticks every second clock
// Notes:   settle windows derived from nominal ns at the default tick period
`timescale 1ns/1ps
`define CHK(a, b, m) begin checks++; if ((a) !== (b)) begin errors++; $display("CHECK FAILED %0t %s", $time, m); end end
bind tsacs_top tsacs_chk i_chk (.*);
module test_touch_sar_adc_config_status;
  logic       sys_clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic       conv_req_i = 1'b0, conv_touch_i = 1'b0, slow = 1'b0, touch = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, rd;
  logic [1:0] conv_chan_i = 2'h0;
  logic [3:0] result_rd_i = 4'h0;
  logic [2:0] panel_code_o;
  logic       tick_i, conv_done_i, pen_i, sample_o, busy_o, ref_internal_o, ref_high_o, ref_power_o;
  logic       battery_pin_mode_o, buffer_en_o, buffer_ptr_clear_o;
  int         errors = 0, checks = 0, lat, t;
  logic [7:0] vals [4] = '{8'h81, 8'h41, 8'h00, 8'h20};
  tsacs_top i_dut (.*);
  tsacs_panel i_panel (.clk_i(sys_clk_i), .rst_i(rst_i), .sample_i(sample_o), .slow_i(slow),
    .touch_i(touch), .tick_o(tick_i), .done_o(conv_done_i), .pen_o(pen_i));
  always #2 sys_clk_i = ~sys_clk_i;
  // counts and verdict
  task automatic finish_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  // one register write, one register read
  task automatic wr(input logic [7:0] a, d);
    @(negedge sys_clk_i) {reg_addr_i, reg_wdata_i, reg_wr_i} = {a, d, 1'b1};
    @(negedge sys_clk_i) reg_wr_i = 1'b0;
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    @(negedge sys_clk_i) {reg_addr_i, reg_rd_i} = {a, 1'b1};
    @(negedge sys_clk_i) reg_rd_i = 1'b0;
    rd = reg_rdata_o;
  endtask : rdr
  // one conversion: time the sample strobe, then wait for idle
  task automatic conv(input logic k, input logic [1:0] c);
    @(negedge sys_clk_i) {conv_req_i, conv_touch_i, conv_chan_i} = {1'b1, k, c};
    @(negedge sys_clk_i) conv_req_i = 1'b0;
    for (lat = 1; lat < 9000 && sample_o !== 1'b1; lat++) @(negedge sys_clk_i);
    if (sample_o !== 1'b1) begin
      errors++;
      finish_test();
    end
    repeat (40) if (busy_o === 1'b1) @(negedge sys_clk_i);
    if (busy_o !== 1'b0) begin
      errors++;
      finish_test();
    end
    @(negedge sys_clk_i);
  endtask : conv
  // reset contents, reserved and unmapped reads
  task automatic t_reset;
    rdr(tsacs_pkg::OFF_REF);
    `CHK(rd, 8'h20, "ref reset")
    rdr(tsacs_pkg::OFF_STATUS);
    `CHK(rd, 8'h40, "status reset")
    rdr(tsacs_pkg::OFF_RSVA);
    `CHK(rd, 8'h00, "reserved reset")
    rdr(8'h30);
    `CHK(rd, 8'h00, "unmapped read")
  endtask : t_reset
  // reference fields, readback, power mode; frozen write ignored
  task automatic t_ref;
    foreach (vals[i]) begin
      wr(tsacs_pkg::OFF_REF, vals[i]);
      `CHK({ref_internal_o, ref_high_o, battery_pin_mode_o}, {vals[i][7], vals[i][6], vals[i][0]}, "ref")
      `CHK(ref_power_o, ~vals[i][5], "ref power idle")
      rdr(tsacs_pkg::OFF_REF);
      `CHK(rd, vals[i], "ref readback")
    end
    ce_i = 1'b0;
    wr(tsacs_pkg::OFF_REF, 8'h81);
    ce_i = 1'b1;
    `CHK(ref_internal_o, 1'b0, "write while frozen")
  endtask : t_ref
  // panel settle for codes 0 to 3, pen flag, per-coordinate and summary flags
  task automatic t_touch;
    touch = 1'b1;
    for (int c = 0; c < 4; c++) begin
      wr(tsacs_pkg::OFF_PANEL, 8'(c));
      `CHK(panel_code_o, 3'(c), "panel code")
      conv(1'b1, 2'(c));
      t = (tsacs_pkg::PANEL_NS[c] + 124) / 125;
      `CHK(lat >= t + 1 && lat <= 2 * t + 4, 1'b1, "panel settle")
    end
    rdr(tsacs_pkg::OFF_STATUS);
    `CHK(rd, 8'hef, "all fresh")
    @(negedge sys_clk_i) result_rd_i = 4'h1;
    @(negedge sys_clk_i) result_rd_i = 4'h0;
    rdr(tsacs_pkg::OFF_STATUS);
    `CHK(rd, 8'he7, "x read out")
    @(negedge sys_clk_i) result_rd_i = 4'he;
    @(negedge sys_clk_i) result_rd_i = 4'h0;
    touch = 1'b0;
    rdr(tsacs_pkg::OFF_STATUS);
    `CHK(rd, 8'h40, "all read out")
  endtask : t_touch
  // reference settle codes with a slow far side
  task automatic t_refsettle;
    slow = 1'b1;
    wr(tsacs_pkg::OFF_REF, 8'h24);
    conv(1'b0, 2'h0);
    `CHK(lat >= 801, 1'b1, "ref settle 100us")
    wr(tsacs_pkg::OFF_REF, 8'h20);
    conv(1'b0, 2'h1);
    `CHK(lat <= 4, 1'b1, "ref settle none")
  endtask : t_refsettle
  // buffer enable and pointer clear
  task automatic t_buffer;
    wr(tsacs_pkg::OFF_BUFFER, 8'h80);
    `CHK(buffer_en_o, 1'b1, "buffer on")
    conv(1'b1, 2'h0);
    rdr(tsacs_pkg::OFF_STATUS);
    `CHK(rd, 8'h40, "no flags in buffer mode")
    wr(tsacs_pkg::OFF_BUFFER, 8'h00);
    `CHK({buffer_ptr_clear_o, buffer_en_o}, 2'h2, "pointer clear")
  endtask : t_buffer
  initial begin
    repeat (2) @(negedge sys_clk_i);
    rst_i = 1'b0;
    t_reset();
    t_ref();
    t_touch();
    t_refsettle();
    t_buffer();
    finish_test();
  end
endmodule : test_touch_sar_adc_config_status
